// [rtl/snm_cfg.svh]
// Constants of the status notice manager: offsets, fields, resets, timing
`ifndef SNM_CFG_SVH
`define SNM_CFG_SVH
`define SNM_CLK_NS      10
`define SNM_TICK_NS     1000000
`define SNM_N           13
`define SNM_HDEPTH      5'h10
`define SNM_NAXIS       6
`define SNM_SPDW        20
`define SNM_CODE_BASE   8'h10
`define SNM_A_CTRL      8'h00
`define SNM_A_CMD       8'h04
`define SNM_A_FLAGS     8'h08
`define SNM_A_USEL      8'h0C
`define SNM_A_TEMP      8'h10
`define SNM_A_TCP       8'h14
`define SNM_A_AXIS      8'h18
`define SNM_A_HCNT      8'h1C
`define SNM_A_HSEL      8'h20
`define SNM_A_HCODE     8'h24
`define SNM_A_HTIME     8'h28
`define SNM_B_AUTO      0
`define SNM_B_MECH      1
`define SNM_B_INV       2
`define SNM_B_CLRN      0
`define SNM_B_CLRH      1
`define SNM_CTRL_RST    3'h3
`define SNM_TEMP_RST    8'h55
`define SNM_I_USER      0
`define SNM_I_TEMP      1
`define SNM_I_TCP       2
`define SNM_I_AXIS      3
`define SNM_I_START     4
`define SNM_I_HOME      5
`define SNM_I_PRE       6
`define SNM_I_MECH      7
`define SNM_I_LINK      8
`define SNM_I_TPOS      9
`define SNM_I_TNEG      10
`define SNM_I_APOS      11
`define SNM_I_ANEG      12
`endif

// [rtl/snm_pkg.sv]
// Types of the status notice manager
`default_nettype none
`include "snm_cfg.svh"
package snm_pkg;
  typedef logic [`SNM_N-1:0] snm_vec_t;
  typedef struct packed {
    logic [7:0]  code;
    logic [3:0]  item;
    logic [31:0] stamp;
  } snm_entry_t;
  typedef snm_entry_t [15:0] snm_mem_t;
  typedef struct packed {
    logic [3:0]  s1, s2, s3, pin, pin_d;
    snm_vec_t    flags, pend;
    logic        summary;
    logic [3:0]  ok;
    logic [3:0]  head;
    logic [4:0]  count;
    logic [31:0] tcnt, stamp;
    logic [2:0]  ctrl;
    logic [3:0]  usel, hsel;
    logic [7:0]  temp_th;
    logic [19:0] tcp_th, axis_th;
    logic        aw_full, w_full;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
  } snm_state_t;
  typedef struct packed {
    snm_mem_t   mem;
    snm_entry_t rdata;
  } snm_mstate_t;
endpackage
`default_nettype wire

// [rtl/snm_hist_if.sv]
// History memory port between the manager and its memory
`default_nettype none
interface snm_hist_if;
  import snm_pkg::*;
  logic       we;
  logic [3:0] waddr;
  logic [3:0] raddr;
  snm_entry_t wdata;
  snm_entry_t rdata;
  modport wr (output we, waddr, wdata, raddr, input rdata);
  modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface
`default_nettype wire

// [rtl/snm_hist_mem.sv]
// Sixteen-entry notice history memory with registered read
`default_nettype none
module snm_hist_mem
  import snm_pkg::*;
(
  input  wire logic   aclk,
  input  wire logic   aresetn,
  snm_hist_if.mem     hp
);
  snm_mstate_t s;
  snm_mstate_t next_s;

  always_comb
  begin
    next_s = s;
    if (hp.we)
    begin
      next_s.mem[hp.waddr] = hp.wdata;
    end
    next_s.rdata = s.mem[hp.raddr];
  end

  // Contents need no reset; the count in the manager says what is valid
  always_ff @(posedge aclk)
  begin
    s <= next_s;
    if (!aresetn)
    begin
      s.rdata <= '0;
    end
  end

  assign hp.rdata = s.rdata;
endmodule
`default_nettype wire

// [rtl/snm_top.sv]
// Status notice manager: notice flags, clearing, history, AXI4-Lite registers
`default_nettype none
`include "snm_cfg.svh"
module snm_top
  import snm_pkg::*;
#(
  parameter int TICK_CYCLES = `SNM_TICK_NS / `SNM_CLK_NS
)
(
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic [31:0]                     s_axi_awaddr,
  input  wire logic [2:0]                      s_axi_awprot,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [31:0]                     s_axi_araddr,
  input  wire logic [2:0]                      s_axi_arprot,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  input  wire logic [15:0]                     user_io,
  input  wire logic [7:0]                      temp_value,
  input  wire logic [19:0]                     tcp_speed,
  input  wire logic [`SNM_NAXIS*`SNM_SPDW-1:0] axis_speed,
  input  wire logic                            start_req,
  input  wire logic                            start_blocked,
  input  wire logic                            motion_ready,
  input  wire logic                            op_started,
  input  wire logic                            user_coords_set_output,
  input  wire logic                            home_all_input,
  input  wire logic                            home_robot_input,
  input  wire logic                            coordinate_preset_input,
  input  wire logic                            origin_rewritten,
  input  wire logic                            mech_mismatch,
  input  wire logic                            link_err,
  input  wire logic                            link_ok,
  input  wire logic [2:0]                      tool_over_pos,
  input  wire logic [2:0]                      tool_over_neg,
  input  wire logic [`SNM_NAXIS-1:0]           axis_over_pos,
  input  wire logic [`SNM_NAXIS-1:0]           axis_over_neg,
  input  wire logic                            notice_clear_input,
  output logic [`SNM_N-1:0]                    notice_bits,
  output logic                                 notice_summary_output
);
  snm_state_t            s;
  snm_state_t            next_s;
  snm_vec_t              raise;
  snm_vec_t              cond;
  snm_vec_t              clr;
  snm_vec_t              newr;
  logic                  clr_req;
  logic                  cmd_clrn;
  logic                  cmd_clrh;
  logic                  do_wr;
  logic                  sel_bit;
  logic [3:0]            pick;
  logic [3:0]            rise;
  logic [31:0]           wm;
  logic [31:0]           rd;
  logic                  rd_ok;
  logic [`SNM_NAXIS-1:0] ax_hi;
  logic [`SNM_NAXIS-1:0] ax_lo;
  snm_hist_if            hif ();

  // Per-axis speed compare against the shared threshold
  for (genvar g = 0; g < `SNM_NAXIS; g++)
  begin : g_ax
    assign ax_hi[g] = axis_speed[g*`SNM_SPDW +: `SNM_SPDW] > s.axis_th;
    assign ax_lo[g] = axis_speed[g*`SNM_SPDW +: `SNM_SPDW] < s.axis_th;
  end

  snm_hist_mem u_mem (
    .aclk    (aclk),
    .aresetn (aresetn),
    .hp      (hif.mem)
  );

  assign hif.we    = |s.pend;
  assign hif.waddr = s.head;
  assign hif.wdata = {`SNM_CODE_BASE + {4'h0, pick}, pick, s.stamp};
  // Newest entry sits at index 0 of the readout
  assign hif.raddr = s.head - 4'h1 - s.hsel;

  always_comb
  begin
    next_s = s;
    // Pins: three stages, a change counts once stages two and three agree
    next_s.s1 = {coordinate_preset_input, home_robot_input, home_all_input,
                 notice_clear_input};
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.pin = (~(s.s2 ^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.pin);
    next_s.pin_d = s.pin;
    rise = s.pin & ~s.pin_d;

    // AXI write channel latches, either order
    do_wr = s.aw_full && s.w_full && !s.bvalid;
    wm = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}}, {8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
    cmd_clrn = do_wr && s.awaddr == `SNM_A_CMD && s.wstrb[0] && s.wdata[`SNM_B_CLRN];
    cmd_clrh = do_wr && s.awaddr == `SNM_A_CMD && s.wstrb[0] && s.wdata[`SNM_B_CLRH];

    // Causes and clear conditions
    raise = '0;
    cond = '0;
    sel_bit = user_io[s.usel] ^ s.ctrl[`SNM_B_INV];
    raise[`SNM_I_USER] = sel_bit;
    cond[`SNM_I_USER] = !sel_bit;
    raise[`SNM_I_TEMP] = temp_value > s.temp_th;
    cond[`SNM_I_TEMP] = temp_value < s.temp_th;
    // Zero threshold disables the speed notices
    raise[`SNM_I_TCP] = s.tcp_th != 20'h0_0000 && tcp_speed > s.tcp_th;
    cond[`SNM_I_TCP] = s.tcp_th == 20'h0_0000 || tcp_speed < s.tcp_th;
    raise[`SNM_I_AXIS] = s.axis_th != 20'h0_0000 && |ax_hi;
    cond[`SNM_I_AXIS] = s.axis_th == 20'h0_0000 || &ax_lo;
    raise[`SNM_I_START] = start_req && (start_blocked || !motion_ready);
    cond[`SNM_I_START] = s.ok[0];
    raise[`SNM_I_HOME] = (rise[1] || rise[2]) && !user_coords_set_output;
    cond[`SNM_I_HOME] = s.ok[1];
    raise[`SNM_I_PRE] = rise[3];
    cond[`SNM_I_PRE] = s.ok[2];
    raise[`SNM_I_MECH] = s.ctrl[`SNM_B_MECH] && mech_mismatch;
    cond[`SNM_I_MECH] = !s.ctrl[`SNM_B_MECH] || !mech_mismatch;
    raise[`SNM_I_LINK] = link_err;
    cond[`SNM_I_LINK] = s.ok[3];
    raise[`SNM_I_TPOS] = |tool_over_pos;
    cond[`SNM_I_TPOS] = ~|tool_over_pos;
    raise[`SNM_I_TNEG] = |tool_over_neg;
    cond[`SNM_I_TNEG] = ~|tool_over_neg;
    raise[`SNM_I_APOS] = |axis_over_pos;
    cond[`SNM_I_APOS] = ~|axis_over_pos;
    raise[`SNM_I_ANEG] = |axis_over_neg;
    cond[`SNM_I_ANEG] = ~|axis_over_neg;

    // Event-type clears are remembered until the notice rises again
    next_s.ok[0] = (s.ok[0] | op_started) & !raise[`SNM_I_START];
    next_s.ok[1] = (s.ok[1] | op_started) & !raise[`SNM_I_HOME];
    next_s.ok[2] = (s.ok[2] | origin_rewritten) & !raise[`SNM_I_PRE];
    next_s.ok[3] = (s.ok[3] | link_ok) & !raise[`SNM_I_LINK];

    clr_req = cmd_clrn || s.pin[0];
    if (s.ctrl[`SNM_B_AUTO])
    begin
      clr = cond;
    end
    else
    begin
      clr = clr_req ? cond : '0;
    end
    // A cause in the clearing cycle wins
    next_s.flags = (s.flags & ~clr) | raise;
    next_s.summary = |next_s.flags;

    // History: one new notice recorded per cycle, lowest index first
    newr = raise & ~s.flags;
    pick = 4'h0;
    for (int i = `SNM_N - 1; i >= 0; i--)
    begin
      if (s.pend[i])
      begin
        pick = 4'(i);
      end
    end
    next_s.pend = newr;
    if (|s.pend)
    begin
      next_s.pend = (s.pend & ~(snm_vec_t'(1) << pick)) | newr;
      next_s.head = s.head + 4'h1;
      // Saturating count; the head overwrites the oldest slot
      if (s.count != `SNM_HDEPTH)
      begin
        next_s.count = s.count + 5'h01;
      end
    end
    if (cmd_clrh)
    begin
      next_s.count = 5'h00;
    end

    // Millisecond time stamp
    next_s.tcnt = s.tcnt + 32'h0000_0001;
    if (s.tcnt == 32'(TICK_CYCLES - 1))
    begin
      next_s.tcnt = 32'h0000_0000;
      next_s.stamp = s.stamp + 32'h0000_0001;
    end

    // AXI write
    if (s_axi_awvalid && s.awready)
    begin
      next_s.aw_full = 1'b1;
      next_s.awaddr = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && s.wready)
    begin
      next_s.w_full = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
    end
    if (do_wr)
    begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = 2'b00;
      unique case (s.awaddr)
        `SNM_A_CTRL:
          next_s.ctrl = 3'(({29'h0, s.ctrl} & ~wm) | (s.wdata & wm));
        `SNM_A_USEL:
          next_s.usel = 4'(({28'h0, s.usel} & ~wm) | (s.wdata & wm));
        `SNM_A_TEMP:
          next_s.temp_th = 8'(({24'h0, s.temp_th} & ~wm) | (s.wdata & wm));
        `SNM_A_TCP:
          next_s.tcp_th = 20'(({12'h0, s.tcp_th} & ~wm) | (s.wdata & wm));
        `SNM_A_AXIS:
          next_s.axis_th = 20'(({12'h0, s.axis_th} & ~wm) | (s.wdata & wm));
        `SNM_A_HSEL:
          next_s.hsel = 4'(({28'h0, s.hsel} & ~wm) | (s.wdata & wm));
        `SNM_A_CMD, `SNM_A_FLAGS, `SNM_A_HCNT, `SNM_A_HCODE, `SNM_A_HTIME: ;
        default:
          next_s.bresp = 2'b10;
      endcase
    end
    // One write at a time: no new address until the response is taken
    next_s.awready = !next_s.aw_full && !next_s.bvalid;
    next_s.wready = !next_s.w_full && !next_s.bvalid;

    // AXI read
    rd = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      `SNM_A_CTRL:  rd = {29'h0, s.ctrl};
      `SNM_A_CMD:   rd = 32'h0000_0000;
      `SNM_A_FLAGS: rd = {19'h0, s.flags};
      `SNM_A_USEL:  rd = {28'h0, s.usel};
      `SNM_A_TEMP:  rd = {24'h0, s.temp_th};
      `SNM_A_TCP:   rd = {12'h0, s.tcp_th};
      `SNM_A_AXIS:  rd = {12'h0, s.axis_th};
      `SNM_A_HCNT:  rd = {27'h0, s.count};
      `SNM_A_HSEL:  rd = {28'h0, s.hsel};
      `SNM_A_HCODE: rd = {20'h0, hif.rdata.item, hif.rdata.code};
      `SNM_A_HTIME: rd = hif.rdata.stamp;
      default:      rd_ok = 1'b0;
    endcase
    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd;
      next_s.rresp = rd_ok ? 2'b00 : 2'b10;
    end
    next_s.arready = !next_s.rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.ctrl <= `SNM_CTRL_RST;
      s.temp_th <= `SNM_TEMP_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign notice_bits = s.flags;
  assign notice_summary_output = s.summary;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  auto_clear_a: assert property (
    s.ctrl[`SNM_B_AUTO] && s.flags[`SNM_I_TEMP] && cond[`SNM_I_TEMP]
    |=> !s.flags[`SNM_I_TEMP]) else $error("auto clear missed");
  manual_hold_a: assert property (
    !s.ctrl[`SNM_B_AUTO] && !clr_req && s.flags[`SNM_I_MECH]
    |=> s.flags[`SNM_I_MECH]) else $error("latched notice dropped");
  cmd_clear_a: assert property (
    !s.ctrl[`SNM_B_AUTO] && cmd_clrn && s.flags[`SNM_I_TPOS]
    |=> s.flags[`SNM_I_TPOS] == !cond[`SNM_I_TPOS]) else $error("command clear wrong");
  pin_clear_a: assert property (
    $rose(s.pin[0]) && !s.ctrl[`SNM_B_AUTO] && s.flags[`SNM_I_APOS] && cond[`SNM_I_APOS]
    |=> !s.flags[`SNM_I_APOS]) else $error("clear input ignored");
  hist_depth_a: assert property (
    s.count <= `SNM_HDEPTH) else $error("history over depth");
  hist_item_a: assert property (
    hif.we |-> s.pend[hif.wdata.item] && hif.wdata.stamp == s.stamp)
    else $error("history entry wrong");
  read_ans_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 s_axi_rvalid [*1])
    else $error("read not answered");
  hist_clr_a: assert property (
    cmd_clrh |=> s.count == 5'h00) else $error("history not cleared");
  temp_rise_a: assert property (
    temp_value > s.temp_th |=> notice_bits[`SNM_I_TEMP]) else $error("temp notice missing");
  summary_a: assert property (
    notice_summary_output == |notice_bits) else $error("summary mismatch");
  hist_wrap_a: assert property (
    s.count == `SNM_HDEPTH && hif.we && !cmd_clrh |=> s.count == `SNM_HDEPTH
    && s.head == $past(s.head) + 4'h1) else $error("wrap wrong");

  full_hist_c: cover property (s.count == `SNM_HDEPTH && hif.we);
  manual_clr_c: cover property (!s.ctrl[`SNM_B_AUTO] && cmd_clrn && |s.flags);
  two_rise_c: cover property ($countones(newr) > 1);
endmodule
`default_nettype wire

// [bench/snm_host.sv]
// Host model: AXI4-Lite master issuing monitor and maintenance commands
`default_nettype none
module snm_host
(
  input  wire logic        aclk,
  output logic [31:0]      s_axi_awaddr,
  output logic [2:0]       s_axi_awprot,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [31:0]      s_axi_araddr,
  output logic [2:0]       s_axi_arprot,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Clear commands travel as register writes
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_p, w_p;
    @(posedge aclk);
    s_axi_awaddr <= {24'h00_0000, a};
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    // Each channel released only at its own handshake edge
    while (aw_p || w_p)
    begin
      @(posedge aclk);
      aw_p = aw_p && !s_axi_awready;
      w_p = w_p && !s_axi_wready;
      s_axi_awvalid <= aw_p;
      s_axi_wvalid <= w_p;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {24'h00_0000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [bench/test_status_notice_flag_manager.sv]
// Self-checking bench of the status notice manager
`default_nettype none
`include "snm_cfg.svh"
module test_status_notice_flag_manager
  import snm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic         s_axi_rready, start_req, start_blocked, motion_ready, op_started;
  logic         user_coords_set_output, home_all_input, home_robot_input, origin_rewritten;
  logic         coordinate_preset_input, mech_mismatch, link_err, link_ok;
  logic         notice_clear_input, notice_summary_output;
  logic [31:0]  s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_data, t_new;
  logic [2:0]   s_axi_awprot, s_axi_arprot, tool_over_pos, tool_over_neg;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp, resp;
  logic [15:0]  user_io;
  logic [7:0]   temp_value;
  logic [19:0]  tcp_speed;
  logic [119:0] axis_speed;
  logic [5:0]   axis_over_pos, axis_over_neg;
  logic [12:0]  notice_bits;
  int           errors, tests_run, seed;

  snm_host i_snm_host (.aclk, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // Short tick keeps history stamps distinct in a brief run
  snm_top #(.TICK_CYCLES(10)) i_snm_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .user_io, .temp_value, .tcp_speed, .axis_speed,
    .start_req, .start_blocked, .motion_ready, .op_started, .user_coords_set_output,
    .home_all_input, .home_robot_input, .coordinate_preset_input, .origin_rewritten,
    .mech_mismatch, .link_err, .link_ok, .tool_over_pos, .tool_over_neg, .axis_over_pos,
    .axis_over_neg, .notice_clear_input, .notice_bits, .notice_summary_output);

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] code_of(input int i);
    return {20'h0_0000, 4'(i), `SNM_CODE_BASE + 8'(i)};
  endfunction

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    i_snm_host.wr(a, d, resp);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    i_snm_host.rd(a, rd_data, resp);
    chk(rd_data, e);
    chk(32'(resp), 32'h0);
  endtask

  // Raise (v=1) or remove (v=0) the cause of notice i; pins need over four edges
  task automatic cause(input int i, input logic v);
    logic [31:0] rnd;
    rnd = $random(seed);
    @(posedge aclk);
    case (i)
      0: user_io <= {rnd[15:1], v};
      1: temp_value <= v ? 8'h60 : 8'h50;
      2: tcp_speed <= v ? 20'h0_0200 : 20'h0_0010;
      3: axis_speed <= v ? (120'h200 << (20 * (rnd % 6))) : 120'h0;
      4: {start_req, start_blocked, op_started} <= {v, v, !v};
      5: {home_all_input, home_robot_input, op_started} <= {v & rnd[0], v & !rnd[0], !v};
      6: {coordinate_preset_input, origin_rewritten} <= {v, !v};
      7: mech_mismatch <= v;
      8: {link_err, link_ok} <= {v, !v};
      9: tool_over_pos <= v ? (3'h1 << (rnd % 3)) : 3'h0;
      10: tool_over_neg <= v ? (3'h1 << (rnd % 3)) : 3'h0;
      11: axis_over_pos <= v ? (6'h01 << (rnd % 6)) : 6'h00;
      default: axis_over_neg <= v ? (6'h01 << (rnd % 6)) : 6'h00;
    endcase
    repeat (6) @(posedge aclk);
    {start_req, start_blocked, op_started, origin_rewritten, link_err, link_ok} <= '0;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    errors++;
    $display("watchdog expired");
    give_verdict();
  end

  initial
  begin
    seed = 53;
    errors = 0;
    tests_run = 0;
    aresetn = 1'b0;
    {user_io, temp_value, tcp_speed, axis_speed} = {16'h0000, 8'h50, 20'h0_0000, 120'h0};
    {start_req, start_blocked, op_started, user_coords_set_output} = 4'h0;
    {home_all_input, home_robot_input, coordinate_preset_input, origin_rewritten} = 4'h0;
    {mech_mismatch, link_err, link_ok, notice_clear_input} = 4'h0;
    {tool_over_pos, tool_over_neg, axis_over_pos, axis_over_neg} = 18'h0_0000;
    motion_ready = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(32'(notice_bits), 32'h0);
    rdchk(`SNM_A_CTRL, 32'h0000_0003);
    rdchk(`SNM_A_TEMP, 32'h0000_0055);
    rdchk(`SNM_A_HCNT, 32'h0);
    i_snm_host.rd(8'h3C, rd_data, resp);
    chk(32'(resp), 32'h0000_0002);
    chk(rd_data, 32'h0);
    $display("test reset done");
    wreg(`SNM_A_TCP, 32'h0000_0100);
    wreg(`SNM_A_AXIS, 32'h0000_0100);
    for (int i = 0; i < 13; i++)
    begin
      cause(i, 1'b1);
      chk(32'(notice_bits), 32'h1 << i);
      chk(32'(notice_summary_output), 32'h1);
      cause(i, 1'b0);
      chk(32'(notice_bits), 32'h0);
      chk(32'(notice_summary_output), 32'h0);
    end
    rdchk(`SNM_A_HCNT, 32'h0000_000D);
    wreg(`SNM_A_HSEL, 32'h0);
    rdchk(`SNM_A_HCODE, code_of(12));
    i_snm_host.rd(`SNM_A_HTIME, rd_data, resp);
    t_new = rd_data;
    wreg(`SNM_A_HSEL, 32'h0000_000C);
    rdchk(`SNM_A_HCODE, code_of(0));
    i_snm_host.rd(`SNM_A_HTIME, rd_data, resp);
    chk(32'(rd_data < t_new), 32'h1);
    $display("test auto clear and history done");
    wreg(`SNM_A_CTRL, 32'h0000_0002);
    cause(11, 1'b1);
    cause(11, 1'b0);
    chk(32'(notice_bits), 32'h0000_0800);
    cause(12, 1'b1);
    wreg(`SNM_A_CMD, 32'h0000_0001);
    @(negedge aclk);
    chk(32'(notice_bits), 32'h0000_1000);
    cause(12, 1'b0);
    chk(32'(notice_bits), 32'h0000_1000);
    @(posedge aclk);
    notice_clear_input <= 1'b1;
    repeat (8) @(posedge aclk);
    notice_clear_input <= 1'b0;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    chk(32'(notice_bits), 32'h0);
    chk(32'(notice_summary_output), 32'h0);
    $display("test manual clear done");
    wreg(`SNM_A_CTRL, 32'h0000_0003);
    repeat (2)
    begin
      cause(0, 1'b1);
      cause(0, 1'b0);
    end
    rdchk(`SNM_A_HCNT, 32'h0000_0010);
    wreg(`SNM_A_HSEL, 32'h0000_000F);
    rdchk(`SNM_A_HCODE, code_of(1));
    wreg(`SNM_A_HSEL, 32'h0);
    rdchk(`SNM_A_HCODE, code_of(0));
    wreg(`SNM_A_CMD, 32'h0000_0002);
    rdchk(`SNM_A_HCNT, 32'h0);
    $display("test history overflow and clear done");
    give_verdict();
  end
endmodule
`default_nettype wire
